//--- rtl/fsbp_pkg.sv
package fsbp_pkg;

    // =========================================================
    // Array geometry
    // =========================================================
    localparam int ADDR_W = 26;
    localparam int SECTOR_W = 10;
    localparam int SECTOR_LSB = 16;
    localparam int SUB32_LSB = 15;
    localparam int SUB4_LSB = 12;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 26'h3ffffff;
    localparam logic [SECTOR_W-1:0] SECTOR_LAST = 10'h3ff;
    localparam logic [10:0] SUB32_LAST = 11'h7ff;
    localparam logic [13:0] SUB4_LAST = 14'h3fff;

    // =========================================================
    // Status register layout
    // =========================================================
    localparam int SR_WRITE_DIS = 7;
    localparam int SR_BP3 = 6;
    localparam int SR_TOP_BOTTOM = 5;
    localparam int SR_BP_LO_HI = 4;
    localparam int SR_BP_LO_LO = 2;
    localparam int SR_WEL = 1;
    localparam int SR_WIP = 0;
    localparam logic [7:0] SR_NV_MASK = 8'hfc;
    localparam logic [7:0] SR_RESET = 8'h00;

    // =========================================================
    // Flag status register layout
    // =========================================================
    localparam int FSR_READY = 7;
    localparam int FSR_ERASE_ERR = 5;
    localparam int FSR_PROG_ERR = 4;
    localparam int FSR_PROT_ERR = 1;
    localparam int FSR_ADDR4 = 0;
    localparam logic [7:0] FSR_ERR_MASK = 8'h32;
    localparam logic [7:0] FSR_RESET = 8'h00;

    // =========================================================
    // Protect codes
    // =========================================================
    localparam logic [3:0] BP_NONE = 4'h0;
    localparam logic [3:0] BP_ALL_FROM = 4'hb;
    localparam logic [3:0] BP_ONE = 4'h1;

    // =========================================================
    // Commands and state
    // =========================================================
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_WRITE_EN = 4'h1,
        OP_WRITE_DIS = 4'h2,
        OP_READ_STATUS = 4'h3,
        OP_WRITE_STATUS = 4'h4,
        OP_PROGRAM = 4'h5,
        OP_ERASE_64K = 4'h6,
        OP_ERASE_32K = 4'h7,
        OP_ERASE_4K = 4'h8,
        OP_BULK_ERASE = 4'h9,
        OP_READ_FLAG = 4'ha,
        OP_CLEAR_FLAG = 4'hb,
        OP_WRITE_NVCFG = 4'hc
    } fsbp_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } fsbp_state_t;

    typedef struct packed {
        fsbp_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } fsbp_cmd_t;

    typedef struct packed {
        fsbp_op_t op;
        logic [ADDR_W-1:0] addr;
    } fsbp_array_t;

    // Default cycle lengths of internal operations
    localparam int CYC_W = 12;
    localparam logic [CYC_W-1:0] CYC_STATUS = 12'h010;
    localparam logic [CYC_W-1:0] CYC_PROGRAM = 12'h040;
    localparam logic [CYC_W-1:0] CYC_ERASE = 12'h100;

endpackage

//--- rtl/fsbp_prot_decode.sv
`timescale 1ns/1ps

module fsbp_prot_decode (
    // Protection setting
    input wire logic [3:0] bp,
    input wire logic bottom,
    // Target sector
    input wire logic [fsbp_pkg::SECTOR_W-1:0] sector,
    // Result
    output logic hit
);

    // =========================================================
    // Range test
    // =========================================================
    // Code n covers 2^(n-1) sectors: the sector index, counted from
    // the anchored end, must shift to zero by n-1 places.
    wire logic [3:0] shift = bp - fsbp_pkg::BP_ONE;
    wire logic [fsbp_pkg::SECTOR_W-1:0] from_end = bottom ? sector : ~sector;
    wire logic in_range = ((from_end >> shift) == '0);
    wire logic all_code = (bp >= fsbp_pkg::BP_ALL_FROM);

    assign hit = (bp != fsbp_pkg::BP_NONE) && (all_code || in_range);

endmodule

//--- rtl/fsbp_busy_timer.sv
`timescale 1ns/1ps

module fsbp_busy_timer #(
    parameter int W = fsbp_pkg::CYC_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic [W-1:0] len,
    // Status
    output logic busy,
    output logic done
);

    if (W < 2) begin
        $error("fsbp_busy_timer: W too small");
    end

    logic [W-1:0] cnt_reg;
    logic busy_reg;
    wire logic last = busy_reg && (cnt_reg <= W'(1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end else if (start) begin
            cnt_reg <= (len == '0) ? W'(1) : len;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - W'(1);
            busy_reg <= !last;
        end
    end

    assign busy = busy_reg;
    assign done = last;

endmodule

//--- rtl/fsbp_status_ctrl.sv
`timescale 1ns/1ps

// Behaviour
// [RULE1] Read-status returns the status byte; write-status updates its nonvolatile bits.
// [RULE2] Write-disable bit set and write-protect pin low: status write ignored.
// [RULE3] Hardware-protected status is left only by raising the write-protect pin.
// [RULE4] Write-disable bit resets to 0, allowing status writes.
// [RULE5] Bit 5 anchors the protected range: 0 top, 1 bottom.
// [RULE6] Protect field sits at status bits 6 and 4:2, bit 6 most significant.
// [RULE7] Nonzero protect field blocks program and erase in the protected range.
// [RULE8] Top anchoring: code n protects 2^(n-1) sectors ending at 1023; 11+ all.
// [RULE9] Bottom anchoring: code n protects 2^(n-1) sectors from 0; 11+ all.
// [RULE10] Write-enable latch is clear after reset.
// [RULE11] Write-enable command sets latch; writes, programs, erases refused while clear.
// [RULE12] Bit 0 reads 1 during status write, config write, program or erase.
// [RULE13] Bulk erase runs only when the protect field is zero.
// [RULE14] Status bit 0 is always the inverse of flag bit 7.
// [RULE15] Array decodes as 1024 64KB sectors, 2048 32KB and 16384 4KB subsectors.
// [RULE16] Program or erase on a protected sector is refused and sets protection error.
// [RULE17] Flag error bits stay set until the clear-flag command.
// [RULE18] Write-enable latch clears on completion or on a protection refusal.
module fsbp_status_ctrl #(
    parameter int CYC_W = fsbp_pkg::CYC_W,
    parameter logic [fsbp_pkg::CYC_W-1:0] STATUS_CYCLES = fsbp_pkg::CYC_STATUS,
    parameter logic [fsbp_pkg::CYC_W-1:0] PROGRAM_CYCLES = fsbp_pkg::CYC_PROGRAM,
    parameter logic [fsbp_pkg::CYC_W-1:0] ERASE_CYCLES = fsbp_pkg::CYC_ERASE
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Write-protect pin
    input wire logic WP_N,
    // Command port
    input wire logic CMD_VALID,
    input wire fsbp_pkg::fsbp_cmd_t CMD,
    output logic CMD_READY,
    // Read answer
    output logic RD_VALID,
    output logic [7:0] RD_DATA,
    // Array operation request
    output logic ARRAY_START,
    output fsbp_pkg::fsbp_array_t ARRAY_REQ,
    // Visible state
    output logic [7:0] STATUS_Q,
    output logic [7:0] FLAG_Q,
    output logic PROT_REFUSE
);

    // =========================================================
    // Parameter checks
    // =========================================================
    if (CYC_W != fsbp_pkg::CYC_W) begin
        $error("fsbp_status_ctrl: CYC_W must match package");
    end
    if (STATUS_CYCLES == '0 || PROGRAM_CYCLES == '0 || ERASE_CYCLES == '0) begin
        $error("fsbp_status_ctrl: op lengths must be nonzero");
    end

    // =========================================================
    // State
    // =========================================================
    fsbp_pkg::fsbp_state_t state_reg;
    fsbp_pkg::fsbp_state_t state_next;
    logic [7:0] nv_reg;
    logic [7:0] nv_pend_reg;
    logic pend_sr_reg;
    logic wel_reg;
    logic wel_next;
    logic erase_err_reg;
    logic prog_err_reg;
    logic prot_err_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic start_reg;
    fsbp_pkg::fsbp_array_t req_reg;
    logic refuse_reg;

    // =========================================================
    // Field decode
    // =========================================================
    function automatic logic [3:0] bp_of(input logic [7:0] sr);
        bp_of = {sr[fsbp_pkg::SR_BP3],
                 sr[fsbp_pkg::SR_BP_LO_HI:fsbp_pkg::SR_BP_LO_LO]}; // [RULE6]
    endfunction

    function automatic logic is_array_op(input fsbp_pkg::fsbp_op_t op);
        is_array_op = (op == fsbp_pkg::OP_PROGRAM) || (op == fsbp_pkg::OP_ERASE_64K)
            || (op == fsbp_pkg::OP_ERASE_32K) || (op == fsbp_pkg::OP_ERASE_4K);
    endfunction

    function automatic logic is_read_op(input fsbp_pkg::fsbp_op_t op);
        is_read_op = (op == fsbp_pkg::OP_READ_STATUS) || (op == fsbp_pkg::OP_READ_FLAG);
    endfunction

    wire logic [3:0] bp = bp_of(nv_reg);
    wire logic bottom = nv_reg[fsbp_pkg::SR_TOP_BOTTOM]; // [RULE5]
    wire logic write_dis = nv_reg[fsbp_pkg::SR_WRITE_DIS];
    // Only the pin or RST releases this; no command touches it
    wire logic hw_locked = write_dis && !WP_N; // [RULE2] [RULE3] [RULE4]

    // Sector of a 26-bit byte address; subsectors lie inside it
    wire logic [fsbp_pkg::ADDR_W-1:0] addr = CMD.addr & fsbp_pkg::ADDR_LAST; // [RULE15]
    wire logic [fsbp_pkg::SECTOR_W-1:0] sector = addr[fsbp_pkg::ADDR_W-1:fsbp_pkg::SECTOR_LSB];
    wire logic [fsbp_pkg::ADDR_W-1:0] base_64k =
        {addr[fsbp_pkg::ADDR_W-1:fsbp_pkg::SECTOR_LSB], {fsbp_pkg::SECTOR_LSB{1'b0}}};
    wire logic [fsbp_pkg::ADDR_W-1:0] base_32k =
        {addr[fsbp_pkg::ADDR_W-1:fsbp_pkg::SUB32_LSB], {fsbp_pkg::SUB32_LSB{1'b0}}};
    wire logic [fsbp_pkg::ADDR_W-1:0] base_4k =
        {addr[fsbp_pkg::ADDR_W-1:fsbp_pkg::SUB4_LSB], {fsbp_pkg::SUB4_LSB{1'b0}}};

    logic sector_hit;

    fsbp_prot_decode u_decode (
        .bp(bp),
        .bottom(bottom),
        .sector(sector),
        .hit(sector_hit)
    ); // [RULE8] [RULE9]

    // =========================================================
    // Busy timer
    // =========================================================
    logic tmr_busy;
    logic tmr_done;
    logic tmr_start;
    logic [CYC_W-1:0] tmr_len;

    fsbp_busy_timer #(
        .W(CYC_W)
    ) u_timer (
        .clk(MCLK),
        .rst(RST),
        .start(tmr_start),
        .len(tmr_len),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // =========================================================
    // Command acceptance
    // =========================================================
    wire logic idle = (state_reg == fsbp_pkg::ST_IDLE);
    // While busy only the polling reads are taken
    assign CMD_READY = idle || is_read_op(CMD.op);
    wire logic take = CMD_VALID && CMD_READY;
    wire fsbp_pkg::fsbp_op_t op = CMD.op;

    wire logic do_wr_status = take && (op == fsbp_pkg::OP_WRITE_STATUS) && wel_reg
        && !hw_locked; // [RULE1] [RULE2] [RULE11]
    wire logic do_nvcfg = take && (op == fsbp_pkg::OP_WRITE_NVCFG) && wel_reg; // [RULE11]
    wire logic arr_try = take && is_array_op(op) && wel_reg; // [RULE11]
    wire logic arr_prot = arr_try && sector_hit; // [RULE7] [RULE16]
    wire logic do_array = arr_try && !sector_hit;
    wire logic bulk_try = take && (op == fsbp_pkg::OP_BULK_ERASE) && wel_reg;
    wire logic do_bulk = bulk_try && (bp == fsbp_pkg::BP_NONE); // [RULE13]
    wire logic bulk_skip = bulk_try && (bp != fsbp_pkg::BP_NONE);
    wire logic sr_locked_try = take && (op == fsbp_pkg::OP_WRITE_STATUS) && wel_reg
        && hw_locked;
    wire logic any_start = do_wr_status || do_nvcfg || do_array || do_bulk;
    wire logic is_prog = (op == fsbp_pkg::OP_PROGRAM);

    assign tmr_start = any_start;
    assign tmr_len = (do_wr_status || do_nvcfg) ? STATUS_CYCLES
        : (do_array && is_prog) ? PROGRAM_CYCLES : ERASE_CYCLES;

    // =========================================================
    // Next-state and latch
    // =========================================================
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fsbp_pkg::ST_IDLE: begin
                if (any_start) begin
                    state_next = fsbp_pkg::ST_BUSY;
                end
            end
            fsbp_pkg::ST_BUSY: begin
                if (tmr_done) begin
                    state_next = fsbp_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = fsbp_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb begin
        wel_next = wel_reg;
        if (take && (op == fsbp_pkg::OP_WRITE_EN) && idle) begin
            wel_next = 1'b1; // [RULE11]
        end else if (take && (op == fsbp_pkg::OP_WRITE_DIS)) begin
            wel_next = 1'b0;
        end else if (arr_prot || bulk_skip || sr_locked_try) begin
            wel_next = 1'b0; // [RULE18]
        end else if (!idle && tmr_done) begin
            wel_next = 1'b0; // [RULE18]
        end
    end

    // =========================================================
    // Read answer
    // =========================================================
    wire logic busy_flag = !idle;
    wire logic [7:0] flag_byte = {!busy_flag, 1'b0, erase_err_reg, prog_err_reg,
                                  2'b00, prot_err_reg, 1'b0};
    // Bit 0 is taken straight from the inverse of the flag ready bit
    wire logic [7:0] status_byte = (nv_reg & fsbp_pkg::SR_NV_MASK)
        | {6'h00, wel_reg, !flag_byte[fsbp_pkg::FSR_READY]}; // [RULE12] [RULE14]

    always_comb begin
        rd_data_next = rd_data_reg;
        if (take && (op == fsbp_pkg::OP_READ_STATUS)) begin
            rd_data_next = status_byte; // [RULE1]
        end else if (take && (op == fsbp_pkg::OP_READ_FLAG)) begin
            rd_data_next = flag_byte;
        end
    end

    // =========================================================
    // Error flags: set wins over clear
    // =========================================================
    wire logic clr_flags = take && (op == fsbp_pkg::OP_CLEAR_FLAG);
    wire logic set_prot = arr_prot; // [RULE16]
    wire logic set_prog = arr_prot && is_prog;
    wire logic set_erase = arr_prot && !is_prog;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            prot_err_reg <= 1'b0;
            prog_err_reg <= 1'b0;
            erase_err_reg <= 1'b0;
        end else begin
            prot_err_reg <= set_prot || (prot_err_reg && !clr_flags); // [RULE17]
            prog_err_reg <= set_prog || (prog_err_reg && !clr_flags); // [RULE17]
            erase_err_reg <= set_erase || (erase_err_reg && !clr_flags); // [RULE17]
        end
    end

    // =========================================================
    // Status register
    // =========================================================
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_reg <= fsbp_pkg::ST_IDLE;
            wel_reg <= 1'b0; // [RULE10]
            nv_reg <= fsbp_pkg::SR_RESET; // [RULE4] [RULE5]
            nv_pend_reg <= fsbp_pkg::SR_RESET;
            pend_sr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wel_reg <= wel_next;
            if (do_wr_status) begin
                nv_pend_reg <= CMD.data & fsbp_pkg::SR_NV_MASK;
                pend_sr_reg <= 1'b1;
            end else if (tmr_done && pend_sr_reg) begin
                nv_reg <= nv_pend_reg; // [RULE1]
                pend_sr_reg <= 1'b0;
            end
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            start_reg <= 1'b0;
            req_reg <= '0;
            refuse_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= take && is_read_op(op);
            start_reg <= do_array || do_bulk;
            refuse_reg <= arr_prot || bulk_skip;
            if (do_array || do_bulk) begin
                req_reg.op <= op;
                case (op)
                    fsbp_pkg::OP_ERASE_64K: req_reg.addr <= base_64k;
                    fsbp_pkg::OP_ERASE_32K: req_reg.addr <= base_32k;
                    fsbp_pkg::OP_ERASE_4K: req_reg.addr <= base_4k;
                    fsbp_pkg::OP_BULK_ERASE: req_reg.addr <= '0;
                    default: req_reg.addr <= addr;
                endcase
            end
        end
    end

    assign RD_DATA = rd_data_reg;
    assign RD_VALID = rd_valid_reg;
    assign ARRAY_START = start_reg;
    assign ARRAY_REQ = req_reg;
    assign STATUS_Q = status_byte;
    assign FLAG_Q = flag_byte;
    assign PROT_REFUSE = refuse_reg;

endmodule

//--- testbench/fsbp_status_ctrl_assertions.sv
`timescale 1ns/1ps

module fsbp_status_ctrl_assertions (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Inputs
    input wire logic WP_N,
    input wire logic CMD_VALID,
    input wire fsbp_pkg::fsbp_cmd_t CMD,
    // Outputs
    input wire logic CMD_READY,
    input wire logic RD_VALID,
    input wire logic [7:0] RD_DATA,
    input wire logic ARRAY_START,
    input wire fsbp_pkg::fsbp_array_t ARRAY_REQ,
    input wire logic [7:0] STATUS_Q,
    input wire logic [7:0] FLAG_Q,
    input wire logic PROT_REFUSE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);

    // =========================================================
    // Decode of the command in flight
    // =========================================================
    wire logic take = CMD_VALID && CMD_READY;
    wire logic [3:0] op = CMD.op;
    wire logic arr_op = (op >= fsbp_pkg::OP_PROGRAM) && (op <= fsbp_pkg::OP_BULK_ERASE);
    wire logic bp_set = ({STATUS_Q[6], STATUS_Q[4:2]} != 4'h0);
    wire logic is_read = (op == fsbp_pkg::OP_READ_STATUS) || (op == fsbp_pkg::OP_READ_FLAG);

    // =========================================================
    // Assertions
    // =========================================================
    busy_mirror_a: assert property (STATUS_Q[0] == !FLAG_Q[7])
        else $error("busy bit is not the inverse of ready");
    read_answer_a: assert property (take && op == fsbp_pkg::OP_READ_STATUS && !STATUS_Q[0]
        |=> RD_VALID && RD_DATA == $past(STATUS_Q)) else $error("status read answer wrong");
    wel_set_a: assert property (take && op == fsbp_pkg::OP_WRITE_EN |=> STATUS_Q[1])
        else $error("write enable did not set latch");
    wel_gate_a: assert property (take && arr_op && !STATUS_Q[1]
        |=> !ARRAY_START && !PROT_REFUSE && !STATUS_Q[0]) else $error("op ran without latch");
    bulk_guard_a: assert property (take && op == fsbp_pkg::OP_BULK_ERASE && STATUS_Q[1] && bp_set
        |=> PROT_REFUSE && !ARRAY_START && !STATUS_Q[0]) else $error("bulk erase not blocked");
    hw_lock_a: assert property (take && op == fsbp_pkg::OP_WRITE_STATUS && STATUS_Q[1]
        && STATUS_Q[7] && !WP_N |=> !STATUS_Q[0] && STATUS_Q[7:2] == $past(STATUS_Q[7:2]))
        else $error("locked status write executed");
    err_hold_a: assert property (FLAG_Q[1] && !(take && op == fsbp_pkg::OP_CLEAR_FLAG)
        |=> FLAG_Q[1]) else $error("protection error dropped");
    start_busy_a: assert property (ARRAY_START |-> STATUS_Q[0] && !PROT_REFUSE)
        else $error("array start without busy");
    busy_block_a: assert property (STATUS_Q[0] && CMD_VALID && !is_read |-> !CMD_READY)
        else $error("command taken while busy");
    refuse_wel_a: assert property (PROT_REFUSE |=> !STATUS_Q[1])
        else $error("latch kept after refusal");
    reset_vals_a: assert property (@(posedge MCLK) disable iff (1'b0) RST
        |=> STATUS_Q == 8'h00 && FLAG_Q == 8'h80 && !RD_VALID) else $error("reset values wrong");

    cover property (take && op == fsbp_pkg::OP_READ_STATUS);
    cover property (ARRAY_START);
    cover property (PROT_REFUSE);
endmodule

bind fsbp_status_ctrl fsbp_status_ctrl_assertions u_fsbp_status_ctrl_assertions (
    .MCLK(MCLK), .RST(RST), .WP_N(WP_N), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .ARRAY_START(ARRAY_START), .ARRAY_REQ(ARRAY_REQ), .STATUS_Q(STATUS_Q),
    .FLAG_Q(FLAG_Q), .PROT_REFUSE(PROT_REFUSE)
);

//--- testbench/fsbp_host.sv
`timescale 1ns/1ps

module fsbp_host (
    // Clock
    input wire logic MCLK,
    // Command port
    output logic CMD_VALID,
    output fsbp_pkg::fsbp_cmd_t CMD,
    input wire logic CMD_READY,
    // Read answer
    input wire logic RD_VALID,
    input wire logic [7:0] RD_DATA
);
    initial begin
        CMD_VALID = 1'b0;
        CMD = '0;
    end

    // =========================================================
    // Command held until taken; fields scrambled once released
    // =========================================================
    task automatic send(input fsbp_pkg::fsbp_op_t op, input logic [25:0] addr,
                        input logic [7:0] data);
        @(posedge MCLK);
        CMD_VALID <= 1'b1;
        CMD <= '{op, addr, data};
        do @(posedge MCLK); while (CMD_READY !== 1'b1);
        CMD_VALID <= 1'b0;
        CMD <= fsbp_pkg::fsbp_cmd_t'(~{op, addr, data});
    endtask

    // Answer is sampled at the edge one cycle after the taking edge
    task automatic read(input fsbp_pkg::fsbp_op_t op, output logic [7:0] val);
        send(op, 26'h0, 8'h00);
        @(posedge MCLK);
        val = (RD_VALID === 1'b1) ? RD_DATA : 8'hxx;
    endtask
endmodule

//--- testbench/flash_status_block_protect_tb.sv
`timescale 1ns/1ps

module flash_status_block_protect_tb;
    logic MCLK, RST, WP_N, CMD_VALID, CMD_READY, RD_VALID, ARRAY_START, PROT_REFUSE;
    fsbp_pkg::fsbp_cmd_t CMD;
    fsbp_pkg::fsbp_array_t ARRAY_REQ;
    logic [7:0] RD_DATA, STATUS_Q, FLAG_Q;
    int err_count = 0;
    int samples_checked = 0;

    fsbp_status_ctrl #(.STATUS_CYCLES(12'h008), .PROGRAM_CYCLES(12'h008),
        .ERASE_CYCLES(12'h008)) u_fsbp_status_ctrl (
        .MCLK(MCLK), .RST(RST), .WP_N(WP_N), .CMD_VALID(CMD_VALID), .CMD(CMD),
        .CMD_READY(CMD_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
        .ARRAY_START(ARRAY_START), .ARRAY_REQ(ARRAY_REQ), .STATUS_Q(STATUS_Q),
        .FLAG_Q(FLAG_Q), .PROT_REFUSE(PROT_REFUSE));

    fsbp_host u_fsbp_host (.MCLK(MCLK), .CMD_VALID(CMD_VALID), .CMD(CMD),
        .CMD_READY(CMD_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA));

    // =========================================================
    // Helpers
    // =========================================================
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_idle();
        logic [7:0] v;
        int n = 0;
        do begin
            u_fsbp_host.read(fsbp_pkg::OP_READ_STATUS, v);
            n++;
        end while (v[0] !== 1'b0 && n < 100);
        chk("idle", 1'b0, v[0]);
    endtask

    task automatic write_status(input logic [7:0] d);
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_EN, 26'h0, 8'h00);
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_STATUS, 26'h0, d);
        wait_idle();
    endtask

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic t_reset();
        logic [7:0] v;
        chk("status", 8'h00, STATUS_Q);
        chk("flag", 8'h80, FLAG_Q);
        u_fsbp_host.read(fsbp_pkg::OP_READ_STATUS, v);
        chk("rdsr", 8'h00, v);
        u_fsbp_host.send(fsbp_pkg::OP_PROGRAM, 26'h0, 8'h00);
        @(posedge MCLK);
        chk("start", 1'b0, ARRAY_START);
        chk("status", 8'h00, STATUS_Q);
    endtask

    task automatic t_wrsr();
        logic [7:0] v;
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_EN, 26'h0, 8'h00);
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_NVCFG, 26'h0, 8'h00);
        u_fsbp_host.read(fsbp_pkg::OP_READ_STATUS, v);
        chk("nvcfg", 8'h03, v);
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_EN, 26'h0, 8'h00);
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_STATUS, 26'h0, 8'h5f);
        u_fsbp_host.read(fsbp_pkg::OP_READ_STATUS, v);
        chk("wip", 1'b1, v[0]);
        wait_idle();
        u_fsbp_host.read(fsbp_pkg::OP_READ_STATUS, v);
        chk("rdsr", 8'h5c, v);
        chk("wel", 1'b0, STATUS_Q[1]);
    endtask

    task automatic t_protect();
        fsbp_pkg::fsbp_op_t ops[4] = '{fsbp_pkg::OP_PROGRAM, fsbp_pkg::OP_ERASE_64K,
            fsbp_pkg::OP_ERASE_32K, fsbp_pkg::OP_ERASE_4K};
        int lsb[4] = '{0, 16, 15, 12};
        fsbp_pkg::fsbp_op_t op;
        logic [25:0] a, m;
        logic [7:0] v;
        logic hit;
        int cnt, s;
        for (int b = 0; b < 2; b++) begin
            for (int c = 0; c < 16; c++) begin
                write_status({1'b0, c[3], b[0], c[2:0], 2'b00});
                cnt = (c == 0) ? 0 : (c >= 11) ? 1024 : (1 << (c - 1));
                for (int k = 0; k < 2; k++) begin
                    s = (b == 1 ? cnt : 1024 - cnt) - k;
                    if (s < 0 || s > 1023) continue;
                    hit = (b == 1) ? (s < cnt) : (s >= 1024 - cnt);
                    op = ops[(c + k) % 4];
                    a = {s[9:0], 16'h9abc};
                    m = ~((26'h1 << lsb[(c + k) % 4]) - 26'h1);
                    u_fsbp_host.send(fsbp_pkg::OP_WRITE_EN, 26'h0, 8'h00);
                    u_fsbp_host.send(op, a, 8'h00);
                    @(posedge MCLK);
                    chk("refuse", hit, PROT_REFUSE);
                    chk("start", !hit, ARRAY_START);
                    if (hit) begin
                        u_fsbp_host.read(fsbp_pkg::OP_READ_FLAG, v);
                        chk("flag", (op == fsbp_pkg::OP_PROGRAM) ? 8'h92 : 8'ha2, v);
                        chk("wel", 1'b0, STATUS_Q[1]);
                        u_fsbp_host.send(fsbp_pkg::OP_CLEAR_FLAG, 26'h0, 8'h00);
                        u_fsbp_host.read(fsbp_pkg::OP_READ_FLAG, v);
                        chk("flag_clr", 8'h80, v);
                    end else begin
                        chk("req", {op, a & m}, ARRAY_REQ);
                        wait_idle();
                    end
                end
            end
        end
    endtask

    task automatic t_bulk();
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_EN, 26'h0, 8'h00);
        u_fsbp_host.send(fsbp_pkg::OP_BULK_ERASE, 26'h0, 8'h00);
        @(posedge MCLK);
        chk("bulk_ref", 1'b1, PROT_REFUSE);
        chk("bulk_st", 1'b0, ARRAY_START);
        chk("bulk_flag", 8'h80, FLAG_Q);
        write_status(8'h00);
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_EN, 26'h0, 8'h00);
        u_fsbp_host.send(fsbp_pkg::OP_BULK_ERASE, 26'h1234567, 8'h00);
        @(posedge MCLK);
        chk("bulk_req", {fsbp_pkg::OP_BULK_ERASE, 26'h0}, ARRAY_REQ);
        wait_idle();
    endtask

    task automatic t_lock();
        logic [7:0] v;
        write_status(8'h80);
        @(posedge MCLK);
        WP_N <= 1'b0;
        write_status(8'h3c);
        u_fsbp_host.read(fsbp_pkg::OP_READ_STATUS, v);
        chk("locked", 8'h80, v);
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_EN, 26'h0, 8'h00);
        u_fsbp_host.send(fsbp_pkg::OP_WRITE_DIS, 26'h0, 8'h00);
        @(posedge MCLK);
        chk("wrdi", 1'b0, STATUS_Q[1]);
        WP_N <= 1'b1;
        write_status(8'h00);
        u_fsbp_host.read(fsbp_pkg::OP_READ_STATUS, v);
        chk("unlocked", 8'h00, v);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end

    initial begin
        RST = 1'b1;
        WP_N = 1'b1;
        repeat (16) @(posedge MCLK);
        RST <= 1'b0;
        t_reset();
        t_wrsr();
        t_protect();
        t_bulk();
        t_lock();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge MCLK);
        err_count++;
        end_of_test();
    end
endmodule
